// *** common/cpf_defines.svh ***
// Constants for the channel protection and fault logic: register map,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from design files only.
`ifndef CPF_DEFINES_SVH
`define CPF_DEFINES_SVH
// Register word indexes on the plain register port
`define CPF_A_OUT 4'h0
`define CPF_A_FUSE0 4'h1
`define CPF_A_FUSE1 4'h2
`define CPF_A_OC0 4'h3
`define CPF_A_OC1 4'h4
`define CPF_A_DIAG0 4'h5
`define CPF_A_DIAG1 4'h6
`define CPF_A_STAT0 4'h7
`define CPF_A_STAT1 4'h8
`define CPF_A_TEMP 4'h9
`define CPF_A_CUR 4'hA
// Fuse curve fields
`define CPF_F_NOM 9:0
`define CPF_F_CLDN 11:10
`define CPF_F_ODLY 15:12
`define CPF_F_TRIP 31:16
// Overcurrent fields
`define CPF_F_LTYPE 1:0
`define CPF_F_INLEN 3:2
`define CPF_F_RATE 7:4
`define CPF_F_INTHR 17:8
`define CPF_F_OCTHR 27:18
// Diagnostic fields
`define CPF_B_OLON 0
`define CPF_B_GAIN 1
`define CPF_B_OLOFF 2
`define CPF_F_PUSTR 4:3
`define CPF_B_OLMASK 5
// Temperature limit fields
`define CPF_F_TABS 9:0
`define CPF_F_TREL 19:10
`define CPF_F_THYS 29:20
// Reset values
`define CPF_RST_FUSE 32'hFFFF_0000
`define CPF_RST_OC 28'h0FF_FF00
`define CPF_RST_TEMP 30'h0A32_83FF
// Timing: one protection tick, in microseconds and clock cycles
`define CPF_CLK_NS 20
`define CPF_TICK_US 1000
`define CPF_TICK_CYC (`CPF_TICK_US * 1000 / `CPF_CLK_NS)
// Periods in ticks
`define CPF_RETRY_TICKS 16'h000A
`define CPF_CLDN_1 16'h0032
`define CPF_CLDN_2 16'h00C8
`define CPF_CLDN_3 16'h03E8
`define CPF_INRUSH_UNIT 16'h0002
// Current code below which the low sense ratio may engage
`define CPF_LOWCUR_CODE 10'h028
`endif

// *** common/cpf_pkg.sv ***
// Types shared by the channel protection and fault logic.
// Assumes nothing beyond a SystemVerilog compiler.
package cpf_pkg;
  typedef enum logic [2:0] {CPF_OFF, CPF_INRUSH, CPF_RUN, CPF_WAIT, CPF_LATCH} cpf_chan_state_t;
  typedef struct packed {
    logic [1:0] out_en;
    logic [1:0][31:0] fuse_cfg;
    logic [1:0][27:0] oc_cfg;
    logic [1:0][5:0] diag_cfg;
    logic [29:0] temp_cfg;
    logic [1:0][4:0] sticky;
    cpf_chan_state_t [1:0] st;
    logic [1:0][15:0] tmr;
    logic [1:0][3:0] ovr_cnt;
    logic [1:0] absolute_temp_limit;
    logic [1:0] relative_temp_limit;
    logic [1:0] rise;
    logic [1:0] oc_cause;
    logic [1:0] fuse_cause;
    logic [1:0] ratio_low;
    logic [1:0] unlatch;
    logic [1:0] fault;
    logic [19:0] tick_cnt;
    logic tick;
    logic [31:0] rdata;
  } cpf_state_t;
  typedef struct packed {
    logic [23:0] acc;
  } cpf_acc_t;
  typedef struct packed {
    logic [1:0] ff;
  } cpf_sync_t;
endpackage

// *** hdl/cpf_rst_sync.sv ***
// Reset release synchroniser for the protection block.
// Assumes an active-low asynchronous reset and one system clock.
`timescale 1ns/10ps
`default_nettype none
module cpf_rst_sync
  import cpf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  output logic o_rst_n
);
  cpf_sync_t s_reg;
  cpf_sync_t s_next;

  // Shift a one in; only the second stage leaves the module
  always_comb begin
    s_next.ff = {s_reg.ff[0], 1'b1};
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rst_n = s_reg.ff[1];
endmodule
`default_nettype wire

// *** hdl/cpf_fuse_acc.sv ***
// Current-squared-over-time accumulator for one channel.
// Assumes a one-cycle tick pulse and a synchronous current code.
`timescale 1ns/10ps
`default_nettype none
module cpf_fuse_acc
  import cpf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic [9:0] i_cur,
  input wire logic [9:0] i_nom,
  output logic [23:0] o_acc
);
  cpf_acc_t a_reg;
  cpf_acc_t a_next;

  // Heat above nominal, cool below; never grows at or below nominal
  always_comb begin
    logic [19:0] cc;
    logic [19:0] nn;
    logic [24:0] sum;
    cc = 20'(i_cur * i_cur);
    nn = 20'(i_nom * i_nom);
    sum = 25'h000_0000;
    a_next = a_reg;
    if (i_tick) begin
      if (i_cur > i_nom) begin
        sum = {1'b0, a_reg.acc} + {5'h00, cc - nn};
        // Saturate rather than wrap, a wrap would forget the heat
        a_next.acc = sum[24] ? 24'hFF_FFFF : sum[23:0];
      end else if (a_reg.acc > {4'h0, nn - cc}) begin
        a_next.acc = a_reg.acc - {4'h0, nn - cc};
      end else begin
        a_next.acc = 24'h00_0000;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_reg <= '0;
    end else begin
      a_reg <= a_next;
    end
  end

  assign o_acc = a_reg.acc;
endmodule
`default_nettype wire

// *** hdl/cpf_prot_core.sv ***
// Two-channel protection core: fuse curve, thermal, overcurrent, retry,
// fault pin, reverse battery and diagnostic steering, with register port.
// Assumes measured codes and comparator levels synchronous to i_clk_sys.
// Summary of operation
// - No fuse shutdown while current below nominal
// - Accumulate current squared, trip above energy
// - Overrange current shuts down after delay
// - Fuse cool-down then retry; 00 latches
// - Thermal absolute or relative limit turns off
// - Absolute clears by hysteresis, relative after retry
// - Capacitive load limits current during inrush
// - Resistive load trips on inrush threshold
// - After inrush, trip at overcurrent threshold
// - Overcurrent retry keeps fault until output risen
// - Short to ground keeps fault indefinitely
// - Reverse battery forces both channels on
// - Low sense ratio engages only under 100 mA
// - Sense gain bit multiplies sense by eight
// - Off-state output above threshold raises fault
// - Off-state open load sets status bit
// - Off-state pull-up strength from configuration
// - Held off until retry done, faults clear
// - Off-state fault follows live comparator
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cpf_defines.svh"
module cpf_prot_core
  import cpf_pkg::*;
#(
  parameter int TICK_CYC = `CPF_TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [1:0][9:0] i_cur_code,
  input wire logic [1:0] i_cur_overrange,
  input wire logic [1:0][9:0] i_temp_fet,
  input wire logic [9:0] i_temp_ctrl,
  input wire logic [1:0] i_vout_risen,
  input wire logic [1:0] i_vout_above_ol,
  input wire logic i_rev_batt,
  output logic [1:0] o_fet_on,
  output logic [1:0] o_cur_limit_en,
  output logic [1:0][3:0] o_charge_rate,
  output logic [1:0] o_sense_ratio_low,
  output logic [1:0] o_sense_gain8,
  output logic [1:0] o_pullup_en,
  output logic [1:0][1:0] o_pullup_str,
  output logic o_fault_pin_o,
  output logic o_fault_pin_oe
);
  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic is_on(input cpf_chan_state_t s);
    is_on = (s == CPF_INRUSH) || (s == CPF_RUN);
  endfunction

  function automatic logic [15:0] cooldown_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h1: cooldown_ticks = `CPF_CLDN_1;
      2'h2: cooldown_ticks = `CPF_CLDN_2;
      default: cooldown_ticks = `CPF_CLDN_3;
    endcase
  endfunction

  function automatic logic [15:0] inrush_ticks(input logic [1:0] sel);
    inrush_ticks = 16'({14'h0000, sel} + 16'h0001) * `CPF_INRUSH_UNIT;
  endfunction

  // ****************************************************************
  // Reset, state and accumulators
  // ****************************************************************
  logic rst_n;
  cpf_state_t r_reg;
  cpf_state_t r_next;
  logic [1:0][23:0] acc;

  cpf_rst_sync u_rst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_rst_n(rst_n)
  );

  // One accumulator per channel so a fault stays local
  for (genvar g = 0; g < 2; g++) begin : g_acc
    cpf_fuse_acc u_acc (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_tick(r_reg.tick),
      .i_cur(i_cur_code[g]),
      .i_nom(r_reg.fuse_cfg[g][`CPF_F_NOM]),
      .o_acc(acc[g])
    );
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic on_now;
    logic f_trip;
    logic o_trip;
    logic c_trip;
    logic abs_set;
    logic rel_set;
    logic ol_live;
    logic [15:0] wait_len;
    on_now = 1'b0;
    f_trip = 1'b0;
    o_trip = 1'b0;
    c_trip = 1'b0;
    abs_set = 1'b0;
    rel_set = 1'b0;
    ol_live = 1'b0;
    wait_len = 16'h0000;
    r_next = r_reg;
    // Protection time base
    r_next.tick = (r_reg.tick_cnt == 20'(TICK_CYC - 1));
    r_next.tick_cnt = r_next.tick ? 20'h0_0000 : r_reg.tick_cnt + 20'h0_0001;

    // Register writes; status bits are write-one-to-clear
    if (i_wr) begin
      unique case (i_addr)
        `CPF_A_OUT: begin
          r_next.out_en = i_wdata[1:0];
          r_next.unlatch = r_reg.unlatch | i_wdata[1:0];
        end
        `CPF_A_FUSE0: r_next.fuse_cfg[0] = i_wdata;
        `CPF_A_FUSE1: r_next.fuse_cfg[1] = i_wdata;
        `CPF_A_OC0: r_next.oc_cfg[0] = i_wdata[27:0];
        `CPF_A_OC1: r_next.oc_cfg[1] = i_wdata[27:0];
        `CPF_A_DIAG0: r_next.diag_cfg[0] = i_wdata[5:0];
        `CPF_A_DIAG1: r_next.diag_cfg[1] = i_wdata[5:0];
        `CPF_A_STAT0: r_next.sticky[0] = r_reg.sticky[0] & ~i_wdata[4:0];
        `CPF_A_STAT1: r_next.sticky[1] = r_reg.sticky[1] & ~i_wdata[4:0];
        `CPF_A_TEMP: r_next.temp_cfg = i_wdata[29:0];
        default: r_next.out_en = r_reg.out_en;
      endcase
    end

    // Register reads; data stand only in the cycle after the strobe
    r_next.rdata = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        `CPF_A_OUT: r_next.rdata = {30'h0000_0000, r_reg.out_en};
        `CPF_A_FUSE0: r_next.rdata = r_reg.fuse_cfg[0];
        `CPF_A_FUSE1: r_next.rdata = r_reg.fuse_cfg[1];
        `CPF_A_OC0: r_next.rdata = {4'h0, r_reg.oc_cfg[0]};
        `CPF_A_OC1: r_next.rdata = {4'h0, r_reg.oc_cfg[1]};
        `CPF_A_DIAG0: r_next.rdata = {26'h000_0000, r_reg.diag_cfg[0]};
        `CPF_A_DIAG1: r_next.rdata = {26'h000_0000, r_reg.diag_cfg[1]};
        `CPF_A_STAT0: r_next.rdata = {21'h00_0000, r_reg.st[0], r_reg.rise[0],
                                      r_reg.relative_temp_limit[0], r_reg.absolute_temp_limit[0], r_reg.sticky[0]};
        `CPF_A_STAT1: r_next.rdata = {21'h00_0000, r_reg.st[1], r_reg.rise[1],
                                      r_reg.relative_temp_limit[1], r_reg.absolute_temp_limit[1], r_reg.sticky[1]};
        `CPF_A_TEMP: r_next.rdata = {2'h0, r_reg.temp_cfg};
        `CPF_A_CUR: r_next.rdata = {6'h00, i_cur_code[1], 6'h00, i_cur_code[0]};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end

    // Each channel runs its own copy of the protection machine
    for (int c = 0; c < 2; c++) begin
      on_now = is_on(r_reg.st[c]);
      wait_len = r_reg.fuse_cause[c] ?
                 cooldown_ticks(r_reg.fuse_cfg[c][`CPF_F_CLDN]) : `CPF_RETRY_TICKS;
      // Thermal detection on absolute and relative limits
      abs_set = i_temp_fet[c] > r_reg.temp_cfg[`CPF_F_TABS];
      rel_set = (i_temp_fet[c] > i_temp_ctrl) &&
                ((i_temp_fet[c] - i_temp_ctrl) > r_reg.temp_cfg[`CPF_F_TREL]);
      // Trip only above nominal, so a load under it never melts
      f_trip = on_now && (acc[c][23:8] > r_reg.fuse_cfg[c][`CPF_F_TRIP]) &&
               (i_cur_code[c] > r_reg.fuse_cfg[c][`CPF_F_NOM]);
      // Overrange delay counted in ticks while the current stays out of range
      o_trip = on_now && i_cur_overrange[c] &&
               (r_reg.ovr_cnt[c] >= r_reg.fuse_cfg[c][`CPF_F_ODLY]);
      if (on_now && i_cur_overrange[c]) begin
        if (r_reg.tick && (r_reg.ovr_cnt[c] != 4'hF)) begin
          r_next.ovr_cnt[c] = r_reg.ovr_cnt[c] + 4'h1;
        end
      end else begin
        r_next.ovr_cnt[c] = 4'h0;
      end
      // Resistive inrush trips on its own limit, then the normal threshold
      c_trip = ((r_reg.st[c] == CPF_INRUSH) && (r_reg.oc_cfg[c][`CPF_F_LTYPE] == 2'h0) &&
                (i_cur_code[c] > r_reg.oc_cfg[c][`CPF_F_INTHR])) ||
               ((r_reg.st[c] == CPF_RUN) &&
                (i_cur_code[c] >= r_reg.oc_cfg[c][`CPF_F_OCTHR]));
      // Low ratio engages only while the load is small
      r_next.ratio_low[c] = r_reg.diag_cfg[c][`CPF_B_OLON] &&
                            (r_reg.ratio_low[c] || (i_cur_code[c] < `CPF_LOWCUR_CODE));
      // Fault held after an overcurrent retry until output has risen, without limit
      if (i_vout_risen[c]) begin
        r_next.rise[c] = 1'b0;
      end

      unique case (r_reg.st[c])
        CPF_OFF: begin
          r_next.unlatch[c] = 1'b0;
          if (r_reg.out_en[c] && !r_reg.absolute_temp_limit[c] && !r_reg.relative_temp_limit[c]) begin
            r_next.st[c] = CPF_INRUSH;
            r_next.tmr[c] = 16'h0000;
          end
        end
        CPF_INRUSH, CPF_RUN: begin
          if (!r_reg.out_en[c]) begin
            r_next.st[c] = CPF_OFF;
            r_next.rise[c] = 1'b0;
          end else if (abs_set || rel_set || f_trip || o_trip || c_trip) begin
            r_next.sticky[c] = r_next.sticky[c] |
                               {1'b0, c_trip, abs_set | rel_set, o_trip, f_trip};
            r_next.oc_cause[c] = c_trip;
            r_next.fuse_cause[c] = f_trip || o_trip;
            r_next.tmr[c] = 16'h0000;
            r_next.unlatch[c] = 1'b0;
            // Cool-down code 00 holds the channel until the host enables it
            if ((f_trip || o_trip) && (r_reg.fuse_cfg[c][`CPF_F_CLDN] == 2'h0)) begin
              r_next.st[c] = CPF_LATCH;
            end else begin
              r_next.st[c] = CPF_WAIT;
            end
          end else if (r_reg.st[c] == CPF_INRUSH) begin
            if (r_reg.tmr[c] >= inrush_ticks(r_reg.oc_cfg[c][`CPF_F_INLEN])) begin
              r_next.st[c] = CPF_RUN;
            end else if (r_reg.tick) begin
              r_next.tmr[c] = r_reg.tmr[c] + 16'h0001;
            end
          end
        end
        CPF_WAIT: begin
          // Off until the period ends and no thermal fault is left
          if (r_reg.tmr[c] >= wait_len) begin
            r_next.relative_temp_limit[c] = 1'b0;
            if (!r_reg.absolute_temp_limit[c]) begin
              r_next.st[c] = r_reg.out_en[c] ? CPF_INRUSH : CPF_OFF;
              r_next.rise[c] = r_reg.out_en[c] && r_reg.oc_cause[c];
              r_next.tmr[c] = 16'h0000;
            end
          end else if (r_reg.tick) begin
            r_next.tmr[c] = r_reg.tmr[c] + 16'h0001;
          end
        end
        CPF_LATCH: begin
          if (r_reg.unlatch[c] && !r_reg.absolute_temp_limit[c] && !r_reg.relative_temp_limit[c]) begin
            r_next.st[c] = CPF_INRUSH;
            r_next.tmr[c] = 16'h0000;
            r_next.unlatch[c] = 1'b0;
          end
        end
        default: r_next.st[c] = CPF_OFF;
      endcase

      // Thermal flags; a new detection wins over the retry clear
      if (abs_set) begin
        r_next.absolute_temp_limit[c] = 1'b1;
      end else if (({1'b0, i_temp_fet[c]} + {1'b0, r_reg.temp_cfg[`CPF_F_THYS]}) <=
                   {1'b0, r_reg.temp_cfg[`CPF_F_TABS]}) begin
        r_next.absolute_temp_limit[c] = 1'b0;
      end
      if (rel_set) begin
        r_next.relative_temp_limit[c] = 1'b1;
      end

      // Off-state open load follows the comparator live
      ol_live = !on_now && !i_rev_batt && r_reg.diag_cfg[c][`CPF_B_OLOFF] &&
                i_vout_above_ol[c];
      if (ol_live) begin
        r_next.sticky[c][4] = 1'b1;
      end
      r_next.fault[c] = (r_next.st[c] == CPF_WAIT) || (r_next.st[c] == CPF_LATCH) ||
                        r_next.rise[c] ||
                        (ol_live && !r_reg.diag_cfg[c][`CPF_B_OLMASK]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.fuse_cfg <= {2{`CPF_RST_FUSE}};
      r_reg.oc_cfg <= {2{`CPF_RST_OC}};
      r_reg.temp_cfg <= `CPF_RST_TEMP;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reverse battery turns the FETs on whatever the host asked
  assign o_fet_on = {is_on(r_reg.st[1]), is_on(r_reg.st[0])} | {2{i_rev_batt}};
  // Capacitive loads are current limited at the charge rate in inrush
  assign o_cur_limit_en[0] = (r_reg.st[0] == CPF_INRUSH) &&
                             (r_reg.oc_cfg[0][`CPF_F_LTYPE] != 2'h0);
  assign o_cur_limit_en[1] = (r_reg.st[1] == CPF_INRUSH) &&
                             (r_reg.oc_cfg[1][`CPF_F_LTYPE] != 2'h0);
  assign o_charge_rate = {r_reg.oc_cfg[1][`CPF_F_RATE], r_reg.oc_cfg[0][`CPF_F_RATE]};
  assign o_sense_ratio_low = r_reg.ratio_low;
  // Sense gain of eight for low current resolution
  assign o_sense_gain8 = {r_reg.diag_cfg[1][`CPF_B_GAIN], r_reg.diag_cfg[0][`CPF_B_GAIN]};
  // Pull-up only while off with detection on
  assign o_pullup_en[0] = !o_fet_on[0] && r_reg.diag_cfg[0][`CPF_B_OLOFF];
  assign o_pullup_en[1] = !o_fet_on[1] && r_reg.diag_cfg[1][`CPF_B_OLOFF];
  assign o_pullup_str = {r_reg.diag_cfg[1][`CPF_F_PUSTR], r_reg.diag_cfg[0][`CPF_F_PUSTR]};
  // Open-drain fault pin: pulls low while any channel is faulted
  assign o_fault_pin_o = 1'b0;
  assign o_fault_pin_oe = |r_reg.fault;
  assign o_rdata = r_reg.rdata;

  // ****************************************************************
  // Checks, each on channel 0 or channel 1 except reverse battery on both
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  fuse_above_nom_a: assert property ($rose(r_reg.sticky[0][0]) |->
    $past(i_cur_code[0]) > $past(r_reg.fuse_cfg[0][`CPF_F_NOM]))
    else $error("fuse trip below nominal");
  fuse_trip_off_a: assert property (is_on(r_reg.st[0]) && r_reg.out_en[0] &&
    acc[0][23:8] > r_reg.fuse_cfg[0][`CPF_F_TRIP] &&
    i_cur_code[0] > r_reg.fuse_cfg[0][`CPF_F_NOM] |=> !is_on(r_reg.st[0]))
    else $error("fuse energy exceeded, channel stays on");
  ovr_delay_a: assert property ($rose(r_reg.sticky[0][1]) |->
    $past(r_reg.ovr_cnt[0]) >= $past(r_reg.fuse_cfg[0][`CPF_F_ODLY]))
    else $error("early overrange trip");
  latch_hold_a: assert property (r_reg.st[0] == CPF_LATCH && !r_reg.unlatch[0]
    |=> r_reg.st[0] == CPF_LATCH) else $error("latched channel left without release");
  // The flag may clear a cycle later if the die cools fast, so look only once
  thermal_off_a: assert property (is_on(r_reg.st[1]) &&
    i_temp_fet[1] > r_reg.temp_cfg[`CPF_F_TABS] |=> !is_on(r_reg.st[1]) && r_reg.absolute_temp_limit[1])
    else $error("thermal fault missed");
  abs_hyst_a: assert property (r_reg.absolute_temp_limit[1] && ({1'b0, i_temp_fet[1]} +
    {1'b0, r_reg.temp_cfg[`CPF_F_THYS]}) > {1'b0, r_reg.temp_cfg[`CPF_F_TABS]}
    |=> r_reg.absolute_temp_limit[1]) else $error("absolute thermal cleared inside hysteresis");
  inrush_trip_a: assert property (r_reg.st[1] == CPF_INRUSH && r_reg.out_en[1] &&
    r_reg.oc_cfg[1][`CPF_F_LTYPE] == 2'h0 &&
    i_cur_code[1] > r_reg.oc_cfg[1][`CPF_F_INTHR] |=> !is_on(r_reg.st[1]))
    else $error("resistive inrush limit missed");
  // A fuse cause may latch instead of wait, so only the switch-off is checked
  run_oc_a: assert property (r_reg.st[0] == CPF_RUN && r_reg.out_en[0] &&
    i_cur_code[0] >= r_reg.oc_cfg[0][`CPF_F_OCTHR] |=> !is_on(r_reg.st[0]))
    else $error("overcurrent missed");
  rise_fault_a: assert property (r_reg.rise[0] && r_reg.out_en[0] &&
    !i_vout_risen[0] |=> o_fault_pin_oe)
    else $error("fault dropped before output rose");
  ol_pin_a: assert property (!is_on(r_reg.st[1]) && !i_rev_batt &&
    r_reg.diag_cfg[1][`CPF_B_OLOFF] && !r_reg.diag_cfg[1][`CPF_B_OLMASK] &&
    i_vout_above_ol[1] |=> o_fault_pin_oe) else $error("open load not shown on pin");
  ol_flag_a: assert property (!is_on(r_reg.st[1]) && !i_rev_batt &&
    r_reg.diag_cfg[1][`CPF_B_OLOFF] && i_vout_above_ol[1] |=> r_reg.sticky[1][4])
    else $error("open load flag not set");
  rev_on_a: assert property (i_rev_batt |-> o_fet_on == 2'b11)
    else $error("reverse battery without auto on");
  ratio_gate_a: assert property ($rose(o_sense_ratio_low[0]) |->
    $past(i_cur_code[0]) < `CPF_LOWCUR_CODE) else $error("ratio change above low current");
  wait_fault_a: assert property (r_reg.st[0] == CPF_WAIT |->
    o_fault_pin_oe && !o_fet_on[0] || i_rev_batt)
    else $error("waiting channel not held with fault");
endmodule
`default_nettype wire

// *** testbench/cpf_load_model.sv ***
// Load and wiring model standing at the switch outputs of both channels.
// Assumes fet requests sampled on i_clk_sys; comparator levels are plain.
`timescale 1ns/10ps
`default_nettype none
module cpf_load_model (
  input wire logic i_clk_sys,
  input wire logic [1:0] i_fet_on,
  input wire logic [1:0] i_short_gnd,
  input wire logic [1:0] i_open_load,
  output logic [1:0] o_vout_risen,
  output logic [1:0] o_vout_above_ol
);
  logic [1:0][1:0] rise_cnt = '0;
  // Output ramps for a few cycles; a short to ground keeps it down while it is applied
  always_ff @(posedge i_clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (!i_fet_on[c] || i_short_gnd[c]) rise_cnt[c] <= 2'h0;
      else if (rise_cnt[c] != 2'h3) rise_cnt[c] <= rise_cnt[c] + 2'h1;
    end
  end
  // Open load lets the pull-up lift an idle output over the threshold
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      o_vout_risen[c] = (rise_cnt[c] == 2'h3);
      o_vout_above_ol[c] = !i_fet_on[c] && i_open_load[c];
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the two-channel protection core.
// Assumes a 50 MHz clock and a shortened protection tick of 4 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rev = 0, f_o, f_oe;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata, rv, seed = 32'h757f, r;
  logic [1:0][9:0] cur = '0, tfet = '0;
  logic [1:0] ovr = '0, risen, above_ol, fet_on, lim, rlow, g8, pu_en, sgnd = '0, opl = '0;
  logic [1:0][3:0] rate;
  logic [1:0][1:0] pu_str;
  int errors = 0, tests_run = 0;
  // ****************************************
  // Clock, design and load
  // ****************************************
  initial forever #10 clk = ~clk;
  cpf_prot_core #(.TICK_CYC(4)) u_cpf_prot_core (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_cur_code(cur), .i_cur_overrange(ovr), .i_temp_fet(tfet), .i_temp_ctrl(10'h000),
    .i_vout_risen(risen), .i_vout_above_ol(above_ol), .i_rev_batt(rev),
    .o_fet_on(fet_on), .o_cur_limit_en(lim), .o_charge_rate(rate),
    .o_sense_ratio_low(rlow), .o_sense_gain8(g8), .o_pullup_en(pu_en),
    .o_pullup_str(pu_str), .o_fault_pin_o(f_o), .o_fault_pin_oe(f_oe));
  cpf_load_model u_cpf_load_model (.i_clk_sys(clk), .i_fet_on(fet_on), .i_short_gnd(sgnd),
    .i_open_load(opl), .o_vout_risen(risen), .o_vout_above_ol(above_ol));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Low ratio engages only with the enable set and a small current
  function automatic logic exp_low(input logic en, input logic [9:0] c);
    return en && (c < 10'h028);
  endfunction
  // One bus cycle; read data is taken in the single cycle it stands
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Wait whole cycles, then sample once the edge has settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, 4'h1, 0); `CHK("fuse0_rst", 32'hFFFF_0000, rv)
    bus(0, 4'h3, 0); `CHK("oc0_rst", 32'h00FF_FF00, rv)
    bus(0, 4'hB, 0); `CHK("unmapped", 32'h0000_0000, rv)
    rev <= 1'b1;
    cyc(2); `CHK("rev_on", 2'b11, fet_on)
    rev <= 1'b0;
    // Zero trip energy: only currents over nominal may blow the fuse
    bus(1, 4'h1, 32'h0000_1600);
    bus(1, 4'h2, 32'h0000_1600);
    // Raise both overcurrent thresholds so random load stays inside them
    bus(1, 4'h3, 32'h0FFF_FF00);
    bus(1, 4'h4, 32'h0FFF_FF00);
    bus(1, 4'h0, 32'h0000_0003);
    cyc(12);
    repeat (150) begin
      r = xs();
      @(posedge clk);
      cur <= {1'b0, r[24:16], 1'b0, r[8:0]};
      cyc(1); `CHK("below_nom", 2'b11, fet_on)
    end
    // Overcurrent on one channel, retry into a shorted output
    bus(1, 4'h3, 32'h0403_FF00);
    @(posedge clk);
    sgnd <= 2'b01;
    cur <= {10'h000, 10'h180};
    cyc(2); `CHK("oc_trip", 2'b10, fet_on)
    cyc(1); `CHK("oc_fault", 1'b1, f_oe)
    cur <= '0;
    cyc(25); `CHK("held_off", 1'b0, fet_on[0])
    cyc(60); `CHK("short_fault", 1'b1, f_oe)
    sgnd <= 2'b00;
    cyc(10); `CHK("risen_clear", 1'b0, f_oe)
    bus(1, 4'h3, 32'h0FFF_FF00);
    // Off-state detection on the second channel, then masked
    bus(1, 4'h0, 32'h0000_0001);
    bus(1, 4'h6, 32'h0000_001C);
    opl <= 2'b10;
    cyc(3); `CHK("ol_fault", 1'b1, f_oe)
    `CHK("pin_data", 1'b0, f_o)
    `CHK("pu_en", 1'b1, pu_en[1])
    `CHK("pu_str", 2'b11, pu_str[1])
    opl <= 2'b00;
    cyc(3); `CHK("ol_follow", 1'b0, f_oe)
    bus(0, 4'h8, 0); `CHK("ol_flag", 1'b1, rv[4])
    bus(1, 4'h6, 32'h0000_003C);
    opl <= 2'b10;
    cyc(3); `CHK("ol_masked", 1'b0, f_oe)
    opl <= 2'b00;
    // Sense gain and low ratio on the first channel
    cur[0] <= 10'h0F0;
    bus(1, 4'h5, 32'h0000_0003);
    cyc(3); `CHK("gain8", 1'b1, g8[0])
    `CHK("ratio_hi", exp_low(1'b1, 10'h0F0), rlow[0])
    cur[0] <= 10'h010;
    cyc(4); `CHK("ratio_lo", exp_low(1'b1, 10'h010), rlow[0])
    // Capacitive load limits during inrush only
    bus(1, 4'h4, 32'h0403_FF51);
    bus(1, 4'h0, 32'h0000_0003);
    cyc(2); `CHK("cap_lim", 1'b1, lim[1])
    `CHK("cap_rate", 4'h5, rate[1])
    cyc(20); `CHK("cap_end", 1'b0, lim[1])
    // Absolute thermal limit on the second channel
    bus(1, 4'h9, 32'h0A32_8100);
    tfet[1] <= 10'h180;
    cyc(3); `CHK("therm_off", 1'b0, fet_on[1])
    bus(0, 4'h8, 0); `CHK("therm_flag", 1'b1, rv[2])
    tfet[1] <= 10'h000;
    // Overrange with latch-off cool-down, released by a host write
    bus(1, 4'h1, 32'hFFFF_13FF);
    ovr <= 2'b01;
    cyc(30);
    ovr <= 2'b00;
    cyc(60); `CHK("latched", 1'b0, fet_on[0])
    bus(0, 4'h7, 0); `CHK("latch_state", 3'h4, rv[10:8])
    bus(1, 4'h0, 32'h0000_0003);
    cyc(4); `CHK("unlatched", 1'b1, fet_on[0])
    // Fuse curve: current over a low nominal heats past a zero trip energy
    bus(1, 4'h1, 32'h0000_1410);
    cur[0] <= 10'h100;
    cyc(12); `CHK("fuse_off", 1'b0, fet_on[0])
    bus(0, 4'h7, 0); `CHK("fuse_flag", 1'b1, rv[0])
    // Resistive inrush on the second channel trips on its own low limit
    bus(1, 4'h4, 32'h0FFC_200C);
    bus(1, 4'h0, 32'h0000_0001);
    cur[1] <= 10'h030;
    bus(1, 4'h0, 32'h0000_0003);
    cyc(3); `CHK("inrush_trip", 1'b0, fet_on[1])
    end_sim();
  end
endmodule
`default_nettype wire
